// ### logic/io_port_pkg.sv
// constants for the general-purpose port and pad configuration block
package io_port_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int NUM_PORTS = 5;
	localparam int PORT_BITS = 8;
	localparam int NUM_PINS  = NUM_PORTS * PORT_BITS;
	localparam int ADDR_W    = 16;

	// ------------------------------------------------------------
	// register indices as printed; byte address is four times these
	// ------------------------------------------------------------
	localparam logic [13:0] PAD_CONFIG_IDX     = 14'h0f3c;
	localparam logic [13:0] SPI_OD_CTRL_IDX    = 14'h0f40;
	localparam logic [13:0] SERIAL_OD_CTRL_IDX = 14'h0f41;
	localparam logic [13:0] CAPTURE_OD_CTRL_IDX = 14'h0f42;
	localparam logic [ADDR_W-1:0] PAD_CONFIG_ADDR     = {PAD_CONFIG_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] SPI_OD_CTRL_ADDR    = {SPI_OD_CTRL_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] SERIAL_OD_CTRL_ADDR =
		{SERIAL_OD_CTRL_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] CAPTURE_OD_CTRL_ADDR =
		{CAPTURE_OD_CTRL_IDX, 2'b00};

	// per-port block: port p sits at PORT_BASE + p * PORT_STRIDE
	localparam logic [ADDR_W-1:0] PORT_BASE   = 16'h0000;
	localparam logic [ADDR_W-1:0] PORT_STRIDE = 16'h0010;
	localparam logic [3:0]        DIR_OFS     = 4'h0;
	localparam logic [3:0]        PINS_OFS    = 4'h4;
	localparam logic [3:0]        HOLD_OFS    = 4'h8;
	localparam logic [ADDR_W-1:0] WALLCLOCK_CONFIG_ADDR = 16'h0100;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int UNIT1_OD_BIT    = 0;
	localparam int UNIT2_OD_BIT    = 1;
	localparam int BUF_SEL_BIT     = 0;
	localparam int OUT_SEL_LSB     = 1;
	localparam int CLK_OUT_EN_BIT  = 2;
	localparam logic [1:0] OD_RESET      = 2'h0;
	localparam logic [2:0] PAD_RESET     = 3'h0;
	localparam logic       WC_EN_RESET   = 1'b0;
	localparam logic [7:0] DIR_RESET     = 8'hff;
	localparam logic [7:0] HOLD_RESET    = 8'h00;

	// clock pin source choices
	localparam logic [1:0] SEL_ALARM    = 2'h0;
	localparam logic [1:0] SEL_SECONDS  = 2'h1;
	localparam logic [1:0] SEL_SOURCE   = 2'h2;

	// ------------------------------------------------------------
	// pins that carry each module's data and clock outputs
	// ------------------------------------------------------------
	localparam logic [NUM_PINS-1:0] CAPTURE1_PINS = 40'h00_0004_0000;
	localparam logic [NUM_PINS-1:0] CAPTURE2_PINS = 40'h00_0002_0000;
	localparam logic [NUM_PINS-1:0] SERIAL1_PINS  = 40'h00_00c0_0000;
	localparam logic [NUM_PINS-1:0] SERIAL2_PINS  = 40'h00_c000_0000;
	localparam logic [NUM_PINS-1:0] SPI1_PINS     = 40'h00_0028_0000;
	localparam logic [NUM_PINS-1:0] SPI2_PINS     = 40'h00_0500_0000;

endpackage : io_port_pkg

// ### logic/io_port_pad_config.sv
// general-purpose ports with open-drain and pad configuration, apb slave
//
// Overview of operation
// R1: up to five general-purpose ports provided
// R2: each port has direction, pin, hold registers
// R3: pin register read returns live pin levels
// R4: hold register read returns stored drive values
// R5: enabled peripheral takes the pin over
// R6: hold zero, direction toggles low or release
// R7: open-drain only on serial, spi, capture outputs
// R8: capture control bit1 unit2, bit0 unit1
// R9: serial control bit1 unit2, bit0 unit1
// R10: spi control bit1 unit2, bit0 unit1
// R11: unimplemented bits read zero, ignore writes
// R12: pad bit0 selects ttl or schmitt buffers
// R13: pad bits 2:1 pick clock pin source
// R14: source choice picks rc or secondary osc
// R15: clock pin driven only while enable set
// R16: direction one releases, zero drives hold
// R17: pin register write updates hold values
// R18: open-drain drives low only, never high
// R19: settings act next cycle, hold untouched
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps

module io_port_pad_config
	import io_port_pkg::*;
(
	input  wire logic                core_clk,          // system clock
	input  wire logic                reset,             // sync, active high
	input  wire logic                psel,              // apb select
	input  wire logic                penable,           // apb access phase
	input  wire logic                pwrite,            // apb write
	input  wire logic [ADDR_W-1:0]   paddr,             // apb byte address
	input  wire logic [31:0]         pwdata,            // apb write data
	input  wire logic [3:0]          pstrb,             // apb byte strobes
	output logic                     pready,            // apb ready
	output logic [31:0]              prdata,            // apb read data
	output logic                     pslverr,           // unmapped address
	input  wire logic [NUM_PINS-1:0] padIn,             // pin levels
	output logic [NUM_PINS-1:0]      padOut,            // pin drive value
	output logic [NUM_PINS-1:0]      padOe,             // pin drive enable
	input  wire logic [NUM_PINS-1:0] periphEnable,      // peripheral owns pin
	input  wire logic [NUM_PINS-1:0] periphOut,         // peripheral value
	input  wire logic [NUM_PINS-1:0] periphOe,          // peripheral enable
	output logic                     parallelBufferTtl, // 1 ttl, 0 schmitt
	input  wire logic                alarmPulse,        // wallclock alarm
	input  wire logic                secondsClock,      // wallclock seconds
	input  wire logic                internalRcOsc,     // rc oscillator
	input  wire logic                secondaryOsc,      // secondary osc
	input  wire logic                clockSourceChoice, // config word bit
	output logic                     clockPinOut,       // clock pin value
	output logic                     clockPinOe         // clock pin enable
);

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	// port number of an address inside the port block, or NUM_PORTS
	function automatic logic [2:0] portOf(input logic [ADDR_W-1:0] a);
		logic [2:0] r;
		r = 3'(NUM_PORTS);
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (a[ADDR_W-1:4] == 12'(p))
				r = 3'(p);
		end
		return r;
	endfunction : portOf

	// register slot inside a port block
	function automatic logic [1:0] slotOf(input logic [ADDR_W-1:0] a);
		logic [1:0] r;
		r = 2'h3;
		if (a[3:0] == DIR_OFS)
			r = 2'h0;
		else if (a[3:0] == PINS_OFS)
			r = 2'h1;
		else if (a[3:0] == HOLD_OFS)
			r = 2'h2;
		return r;
	endfunction : slotOf

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [NUM_PINS-1:0] direction;     // direction_register bits
	logic [NUM_PINS-1:0] hold;          // output_hold_register bits
	logic [NUM_PINS-1:0] pinMeta;       // first sync stage
	logic [NUM_PINS-1:0] pinSync;       // second sync stage
	logic [1:0]          captureOd;     // capture_open_drain_ctrl
	logic [1:0]          serialOd;      // serial_open_drain_ctrl
	logic [1:0]          spiOd;         // spi_open_drain_ctrl
	logic [2:0]          padCfg;        // pad_config
	logic                clockOutEn;    // wallclock_config bit 2

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire logic [2:0] selPort   = portOf(paddr);
	wire logic [1:0] selSlot   = slotOf(paddr);
	wire logic       hitPort   = (selPort != 3'(NUM_PORTS)) &&
		(selSlot != 2'h3);
	wire logic       hitCap    = (paddr == CAPTURE_OD_CTRL_ADDR);
	wire logic       hitSer    = (paddr == SERIAL_OD_CTRL_ADDR);
	wire logic       hitSpi    = (paddr == SPI_OD_CTRL_ADDR);
	wire logic       hitPad    = (paddr == PAD_CONFIG_ADDR);
	wire logic       hitWc     = (paddr == WALLCLOCK_CONFIG_ADDR);
	wire logic       hitAny    = hitPort | hitCap | hitSer | hitSpi |
		hitPad | hitWc;
	wire logic       setup     = psel & ~penable;
	wire logic       wrDone    = psel & penable & pready & pwrite &
		hitAny & pstrb[0];
	wire logic [7:0] wrByte    = pwdata[7:0];

	// read mux, only bits that exist are returned, rest read zero
	logic [7:0] portRead;
	always_comb begin
		portRead = 8'h00;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (selPort == 3'(p)) begin
				unique case (selSlot)
					2'h0:    portRead = direction[p*PORT_BITS +: PORT_BITS];
					2'h1:    portRead = pinSync[p*PORT_BITS +: PORT_BITS]; // R3
					2'h2:    portRead = hold[p*PORT_BITS +: PORT_BITS];    // R4
					default: portRead = 8'h00;
				endcase
			end
		end
	end

	wire logic [7:0] next_readByte =
		hitPort ? portRead :
		hitCap  ? {6'h00, captureOd} :                              // R11
		hitSer  ? {6'h00, serialOd} :
		hitSpi  ? {6'h00, spiOd} :
		hitPad  ? {5'h00, padCfg} :
		hitWc   ? {5'h00, clockOutEn, 2'h0} : 8'h00;

	// apb answer: ready and data registered in the setup cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			prdata  <= setup ? {24'h00_0000, next_readByte} : prdata;
			pslverr <= setup & ~hitAny;
		end
	end

	// ------------------------------------------------------------
	// port registers, one byte per port
	// ------------------------------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port          // R1
			wire logic hitMe = wrDone & hitPort && (selPort == 3'(gp));
			// direction and hold registers of this port
			always_ff @(posedge core_clk) begin                          // R2
				if (reset) begin
					direction[gp*PORT_BITS +: PORT_BITS] <= DIR_RESET;
					hold[gp*PORT_BITS +: PORT_BITS]      <= HOLD_RESET;
				end else begin
					if (hitMe && selSlot == 2'h0)
						direction[gp*PORT_BITS +: PORT_BITS] <= wrByte;
					if (hitMe && selSlot != 2'h0)
						hold[gp*PORT_BITS +: PORT_BITS] <= wrByte;      // R17
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// open-drain, pad and wallclock control registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			captureOd  <= OD_RESET;                                        // R8
			serialOd   <= OD_RESET;                                        // R9
			spiOd      <= OD_RESET;                                        // R10
			padCfg     <= PAD_RESET;
			clockOutEn <= WC_EN_RESET;
		end else begin
			if (wrDone && hitCap)
				captureOd <= wrByte[1:0];                                    // R11
			if (wrDone && hitSer)
				serialOd <= wrByte[1:0];
			if (wrDone && hitSpi)
				spiOd <= wrByte[1:0];
			if (wrDone && hitPad)
				padCfg <= wrByte[2:0];
			if (wrDone && hitWc)
				clockOutEn <= wrByte[CLK_OUT_EN_BIT];
		end
	end

	// ------------------------------------------------------------
	// pin input synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pinMeta <= '0;
			pinSync <= '0;
		end else begin
			pinMeta <= padIn;
			pinSync <= pinMeta;
		end
	end

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	// which pins have open-drain on, per module enable
	wire logic [NUM_PINS-1:0] odPins =                                  // R7
		({NUM_PINS{captureOd[UNIT1_OD_BIT]}} & CAPTURE1_PINS) |  // R8
		({NUM_PINS{captureOd[UNIT2_OD_BIT]}} & CAPTURE2_PINS) |  // R8
		({NUM_PINS{serialOd[UNIT1_OD_BIT]}}  & SERIAL1_PINS)  |  // R9
		({NUM_PINS{serialOd[UNIT2_OD_BIT]}}  & SERIAL2_PINS)  |  // R9
		({NUM_PINS{spiOd[UNIT1_OD_BIT]}}     & SPI1_PINS)     |  // R10
		({NUM_PINS{spiOd[UNIT2_OD_BIT]}}     & SPI2_PINS);       // R10

	wire logic [NUM_PINS-1:0] odActive = odPins & periphEnable;

	// peripheral wins; open-drain pins only ever pull low
	wire logic [NUM_PINS-1:0] next_padOe =
		(periphEnable & ~odActive & periphOe) |                           // R5
		(odActive & periphOe & ~periphOut) |                              // R18
		(~periphEnable & ~direction);                                     // R16
	wire logic [NUM_PINS-1:0] next_padOut =
		(periphEnable & ~odActive & periphOut) |
		(~periphEnable & hold);                                           // R6

	always_ff @(posedge core_clk) begin
		if (reset) begin
			padOut <= '0;
			padOe  <= '0;
		end else begin
			padOut <= next_padOut;                                          // R19
			padOe  <= next_padOe;
		end
	end

	// ------------------------------------------------------------
	// buffer select and clock pin
	// ------------------------------------------------------------
	// clock pin sources run off other clocks, two flops before any use
	logic [3:0] srcMeta;    // first sync stage
	logic [3:0] srcSync;    // second sync stage
	always_ff @(posedge core_clk) begin
		if (reset) begin
			srcMeta <= 4'h0;
			srcSync <= 4'h0;
		end else begin
			srcMeta <= {alarmPulse, secondsClock, internalRcOsc,
				secondaryOsc};
			srcSync <= srcMeta;
		end
	end

	wire logic [1:0] outSel     = padCfg[OUT_SEL_LSB +: 2];
	wire logic       srcClk     = clockSourceChoice ? srcSync[0] :
		srcSync[1];                                                   // R14
	wire logic next_clockPinOut =
		(outSel == SEL_ALARM)   ? srcSync[3] :                        // R13
		(outSel == SEL_SECONDS) ? srcSync[2] :
		(outSel == SEL_SOURCE)  ? srcClk : 1'b0;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			parallelBufferTtl <= 1'b0;
			clockPinOut       <= 1'b0;
			clockPinOe        <= 1'b0;
		end else begin
			parallelBufferTtl <= padCfg[BUF_SEL_BIT];                       // R12
			clockPinOut       <= clockOutEn & next_clockPinOut;
			clockPinOe        <= clockOutEn;                                // R15
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	hold_write_a: assert property ( // R17
		(wrDone && hitPort && selPort == 3'h0 && selSlot == 2'h1)
		|=> hold[7:0] == $past(pwdata[7:0]))
		else $error("pin register write did not reach hold");

	pin_read_a: assert property ( // R3
		(setup && hitPort && selPort == 3'h1 && selSlot == 2'h1)
		|=> prdata[7:0] == $past(pinSync[15:8]))
		else $error("pin read not live pin level");

	gpio_drive_a: assert property ( // R16
		!periphEnable[0] |=> padOe[0] == !$past(direction[0]) &&
		padOut[0] == $past(hold[0]))
		else $error("gpio drive wrong");

	periph_take_a: assert property ( // R5
		(periphEnable[22] && !odActive[22])
		|=> padOe[22] == $past(periphOe[22]) &&
		padOut[22] == $past(periphOut[22]))
		else $error("peripheral did not own pin");

	od_low_only_a: assert property ( // R18
		odActive[18] |=> !padOut[18] &&
		padOe[18] == ($past(periphOe[18]) && !$past(periphOut[18])))
		else $error("open-drain pin drove high");

	unimpl_zero_a: assert property ( // R11
		(setup && (hitCap || hitSer || hitSpi || hitPad))
		|=> prdata[31:3] == 29'h0 && !pslverr)
		else $error("unimplemented bits not zero");

	clock_pin_en_a: assert property ( // R15
		!clockOutEn ##1 !clockOutEn |-> !clockPinOe && !clockPinOut)
		else $error("clock pin driven while disabled");

	clock_sel_a: assert property ( // R13
		(clockOutEn && outSel == 2'h3) |=> !clockPinOut)
		else $error("reserved clock select drove pin");

	buffer_sel_a: assert property ( // R12
		$changed(padCfg[0]) |=> parallelBufferTtl == $past(padCfg[0]))
		else $error("buffer select lag wrong");

	od_reset_a: assert property ( // R8
		$fell(reset) |-> captureOd == OD_RESET && serialOd == OD_RESET &&
		spiOd == OD_RESET && padCfg == PAD_RESET)
		else $error("control registers not at reset value");

	hold_untouched_a: assert property ( // R19
		(wrDone && (hitCap || hitSer || hitSpi || hitPad))
		|=> $stable(hold) && $stable(direction))
		else $error("control write disturbed port values");

	apb_ready_a: assert property (
		setup |=> pready ##1 !pready || setup)
		else $error("apb ready timing wrong");

	cover_write_c: cover property (wrDone && hitCap);
	cover_od_c:    cover property (odActive[18] && periphOe[18]);
	cover_err_c:   cover property (pslverr && pready);
	cover_clk_c:   cover property (clockPinOe && outSel == SEL_SOURCE);
	cover_take_c:  cover property (periphEnable[22] && !odActive[22]);

endmodule : io_port_pad_config

// ### sim/pin_partner.sv
// pin model: external pull-up on every pin of the five ports
`timescale 1ns/1ps

module pin_partner
	import io_port_pkg::*;
(
	input  wire logic [NUM_PINS-1:0] padOut, // device drive value
	input  wire logic [NUM_PINS-1:0] padOe,  // device drive enable
	output logic      [NUM_PINS-1:0] padIn   // resolved pin level
);
	// a released pin floats up to the pull-up level, never holds old value
	assign padIn = (padOut & padOe) | ~padOe;
endmodule : pin_partner

// ### sim/tb.sv
// self-checking bench for the general-purpose port and pad block
`timescale 1ns/1ps

module tb
	import io_port_pkg::*;
;
	// ------------------------------------------------------------
	// signals and tables
	// ------------------------------------------------------------
	logic                core_clk = 1'b0;
	logic                reset = 1'b1;
	logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0]   paddr = '0;
	logic [31:0]         pwdata = '0;
	logic [3:0]          pstrb = '0;
	logic                pready, pslverr, parallelBufferTtl;
	logic [31:0]         prdata;
	logic [NUM_PINS-1:0] padIn, padOut, padOe;
	logic [NUM_PINS-1:0] periphEnable = '0, periphOut = '0, periphOe = '0;
	logic                alarmPulse = 1'b0, secondsClock = 1'b0;
	logic                internalRcOsc = 1'b0, secondaryOsc = 1'b0;
	logic                clockSourceChoice = 1'b0;
	logic                clockPinOut, clockPinOe;
	int                  miscompares = 0, tests_run = 0;
	logic [31:0]         seed = 32'h3208_304b;
	typedef struct {logic [31:0] d; logic e; logic rd;} note_s;
	note_s               notes[$];
	logic [ADDR_W-1:0]   cfg [4] = '{PAD_CONFIG_ADDR, SPI_OD_CTRL_ADDR,
		SERIAL_OD_CTRL_ADDR, CAPTURE_OD_CTRL_ADDR};
	logic [ADDR_W-1:0]   ureg [6] = '{CAPTURE_OD_CTRL_ADDR,
		CAPTURE_OD_CTRL_ADDR, SERIAL_OD_CTRL_ADDR, SERIAL_OD_CTRL_ADDR,
		SPI_OD_CTRL_ADDR, SPI_OD_CTRL_ADDR};
	logic [NUM_PINS-1:0] umask [6] = '{CAPTURE1_PINS, CAPTURE2_PINS,
		SERIAL1_PINS, SERIAL2_PINS, SPI1_PINS, SPI2_PINS};

	always #5 core_clk = ~core_clk;

	io_port_pad_config dut (.core_clk(core_clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOe(padOe),
		.periphEnable(periphEnable), .periphOut(periphOut),
		.periphOe(periphOe), .parallelBufferTtl(parallelBufferTtl),
		.alarmPulse(alarmPulse), .secondsClock(secondsClock),
		.internalRcOsc(internalRcOsc), .secondaryOsc(secondaryOsc),
		.clockSourceChoice(clockSourceChoice), .clockPinOut(clockPinOut),
		.clockPinOe(clockPinOe));

	pin_partner pins (.padOut(padOut), .padOe(padOe), .padIn(padIn));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	function automatic logic [ADDR_W-1:0] pa(int p, logic [3:0] o);
		return 16'(PORT_BASE + PORT_STRIDE * p + o);
	endfunction : pa

	task automatic chk(string what, logic [39:0] exp, logic [39:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one apb transfer; the expected answer is noted before it starts
	task automatic apb(logic w, logic [15:0] a, logic [7:0] d, logic s,
		logic [7:0] x, logic e);
		notes.push_back('{32'(x), e, !w});
		seed = lfsr(seed);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {seed[31:8], d};
		pstrb <= 4'(s);
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(logic [15:0] a, logic [7:0] d);
		apb(1'b1, a, d, 1'b1, 8'h00, 1'b0);
	endtask : wr

	task automatic rd(logic [15:0] a, logic [7:0] x);
		apb(1'b0, a, 8'h00, 1'b1, x, 1'b0);
	endtask : rd

	task automatic settle(int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask : settle

	task automatic end_sim();
		$display("compares %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	// monitor: takes the oldest note off the queue as each transfer ends
	always @(posedge core_clk) begin
		note_s n;
		if (psel && penable && pready === 1'b1) begin
			n = notes.pop_front();
			if (n.rd)
				chk("prdata", 40'(n.d), 40'(prdata));
			chk("pslverr", 40'(n.e), 40'(pslverr));
		end
	end

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		end_sim();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] v;
		logic       e;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		// reset values
		for (int i = 0; i < 4; i++)
			rd(cfg[i], 8'h00);
		rd(WALLCLOCK_CONFIG_ADDR, 8'h00);
		for (int p = 0; p < NUM_PORTS; p++) begin
			rd(pa(p, DIR_OFS), DIR_RESET);
			rd(pa(p, HOLD_OFS), HOLD_RESET);
		end
		chk("padOe", '0, padOe);
		$display("test reset done");
		// config registers: loose bits, strobe and unmapped address
		for (int i = 0; i < 4; i++) begin
			wr(cfg[i], 8'hff);
			rd(cfg[i], (i == 0) ? 8'h07 : 8'h03);
		end
		settle(2);
		chk("bufferTtl", 40'h1, 40'(parallelBufferTtl));
		apb(1'b1, cfg[1], 8'h00, 1'b0, 8'h00, 1'b0);
		rd(cfg[1], 8'h03);
		apb(1'b1, 16'h0ffc, 8'h5a, 1'b1, 8'h00, 1'b1);
		apb(1'b0, 16'h0ffc, 8'h00, 1'b1, 8'h00, 1'b1);
		for (int i = 0; i < 4; i++)
			wr(cfg[i], 8'h00);
		settle(2);
		chk("bufferTtl", 40'h0, 40'(parallelBufferTtl));
		$display("test config done");
		// ports: hold, direction and live pin levels
		for (int p = 0; p < NUM_PORTS; p++) begin
			seed = lfsr(seed);
			v = seed[7:0];
			wr(pa(p, PINS_OFS), v);
			rd(pa(p, HOLD_OFS), v);
			wr(pa(p, DIR_OFS), 8'h00);
			settle(2);
			chk("padOut", 40'(v), 40'(padOut[p*8+:8]));
			chk("padOe", 40'hff, 40'(padOe[p*8+:8]));
			settle(3);
			rd(pa(p, PINS_OFS), v);
			wr(pa(p, HOLD_OFS), 8'h00);
			wr(pa(p, DIR_OFS), 8'hff);
			settle(4);
			rd(pa(p, PINS_OFS), 8'hff);
			rd(pa(p, HOLD_OFS), 8'h00);
			wr(pa(p, DIR_OFS), 8'h00);
			settle(2);
			chk("padOe", 40'hff, 40'(padOe[p*8+:8]));
			chk("padOut", 40'h0, 40'(padOut[p*8+:8]));
			wr(pa(p, DIR_OFS), 8'hff);
		end
		$display("test ports done");
		// peripheral override and open-drain per unit
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk);
			periphEnable <= umask[i];
			periphOe <= umask[i];
			periphOut <= umask[i];
			settle(2);
			chk("padOe", umask[i], padOe & umask[i]);
			chk("padOut", umask[i], padOut & umask[i]);
			wr(ureg[i], 8'(1 << (i % 2)));
			settle(1);
			chk("padOe", '0, padOe & umask[i]);
			@(posedge core_clk);
			periphOut <= '0;
			settle(2);
			chk("padOe", umask[i], padOe & umask[i]);
			chk("padOut", '0, padOut & umask[i]);
			wr(ureg[i], 8'h00);
		end
		rd(pa(2, HOLD_OFS), 8'h00);
		$display("test open drain done");
		// wallclock pin source selection and enable
		wr(WALLCLOCK_CONFIG_ADDR, 8'hff);
		rd(WALLCLOCK_CONFIG_ADDR, 8'h04);
		for (int s = 0; s < 4; s++) begin
			wr(PAD_CONFIG_ADDR, 8'(s << 1));
			for (int k = 0; k < 4; k++) begin
				@(posedge core_clk);
				seed = lfsr(seed);
				{alarmPulse, secondsClock, internalRcOsc} <= seed[2:0];
				{secondaryOsc, clockSourceChoice} <= seed[4:3];
				settle(4);
				e = (s == 0) ? alarmPulse : (s == 1) ? secondsClock :
					(s == 2) ? (clockSourceChoice ? secondaryOsc :
					internalRcOsc) : 1'b0;
				chk("clockPinOut", 40'(e), 40'(clockPinOut));
				chk("clockPinOe", 40'h1, 40'(clockPinOe));
			end
		end
		wr(WALLCLOCK_CONFIG_ADDR, 8'h00);
		settle(2);
		chk("clockPinOe", 40'h0, 40'(clockPinOe));
		$display("test clock pin done");
		end_sim();
	end
endmodule : tb
